// >>> osa_acc_if.sv
// Control signals from the sequencer to the channel accumulators
`timescale 1ns/10ps
interface osa_acc_if;
    import osa_pkg::*;

    logic       clear;
    logic       add;
    osa_ratio_t shift;

    modport ctrl (output clear, output add, output shift);
    modport acc  (input clear, input add, input shift);
endinterface : osa_acc_if

// >>> osa_chan_acc.sv
// One channel accumulator with divide-by-ratio shift
`timescale 1ns/10ps
`include "osa_map.svh"
module osa_chan_acc
    import osa_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    osa_acc_if.acc     ctl,
    input  osa_sample_t sample,
    output osa_sample_t average
);

    osa_acc_t acc_q;
    osa_acc_t acc_d;
    osa_acc_t shifted;

    always_comb begin
        acc_d = acc_q;
        if (ctl.clear) begin
            acc_d = '0;
        end else if (ctl.add) begin
            acc_d = acc_q + osa_acc_t'(sample);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    // Sum of N full-range samples fits the 24-bit sum, so the shift never loses sign
    assign shifted = acc_q >>> ctl.shift;
    assign average = osa_sample_t'(shifted[`OSA_DATA_W-1:0]);

    a_acc_clear: assert property (@(posedge clk) disable iff (!rst_n)
        ctl.clear |=> acc_q == '0)
        else $error("accumulator not cleared");

    a_acc_add_sample: assert property (@(posedge clk) disable iff (!rst_n)
        (ctl.add && !ctl.clear) |=> acc_q == $past(acc_q) + osa_acc_t'($past(sample)))
        else $error("accumulator did not add sample");

endmodule : osa_chan_acc

// >>> osa_core_model.sv
// Converter core model: answers each sample strobe with one sample set
`timescale 1ns/10ps
module osa_core_model (
    input  wire logic       clk,
    input  wire logic [2:0] dly,
    input  wire logic       sample_strobe,
    output logic            sample_done
);
    initial sample_done = 1'b0;
    // Blocking wait: a strobe never arrives before the previous sample was taken
    always @(posedge clk) begin
        if (sample_strobe === 1'b1) begin
            repeat (dly) @(posedge clk);
            sample_done <= 1'b1;
            @(posedge clk);
            sample_done <= 1'b0;
        end
    end
endmodule : osa_core_model

// >>> osa_ctrl.sv
// Oversampling sequencer, busy timing and output result registers
//
// Function
// - ratio_select bit 2 is the most significant, bit 0 the least.
// - Ratio is captured when busy falls and used for the next conversion.
// - Codes 000..110 select 1,2,4..64; code 111 is invalid.
// - Each channel result is delivered as 18 bits for every ratio.
// - First sample on start rising edge, remaining N-1 on internal strobe.
// - The N samples of each channel are averaged into one result.
// - Busy stays high the whole conversion and lengthens with ratio.
// - Result registers load at the falling edge of busy.
`timescale 1ns/10ps
`include "osa_map.svh"
module osa_ctrl
    import osa_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          start_group_a,
    input  wire logic                          start_group_b,
    input  wire logic [`OSA_RATIO_W-1:0]       ratio_select,
    input  wire logic                          sample_done,
    input  osa_sample_t [`OSA_CHANNELS-1:0]    sample_data,
    output logic                               busy,
    output logic                               sample_strobe,
    output logic                               result_ready,
    output osa_sample_t [`OSA_CHANNELS-1:0]    result_data
);

    osa_state_t                        state_q;
    osa_state_t                        state_d;
    logic                              busy_q;
    logic                              busy_d;
    logic                              start_prev_q;
    logic                              start_rise;
    osa_ratio_t                        ratio_q;
    osa_ratio_t                        ratio_d;
    logic [`OSA_CNT_W-1:0]             cnt_q;
    logic [`OSA_CNT_W-1:0]             cnt_d;
    logic [`OSA_CNT_W-1:0]             cnt_next;
    logic [`OSA_CNT_W-1:0]             target;
    logic                              ready_q;
    logic                              ready_d;
    osa_sample_t [`OSA_CHANNELS-1:0]   result_q;
    osa_sample_t [`OSA_CHANNELS-1:0]   result_d;
    osa_sample_t [`OSA_CHANNELS-1:0]   avg_w;
    logic [`OSA_LEN_W-1:0]             busy_len_q;

    osa_acc_if acc_bus ();

    // Both groups share one start when oversampling; the rising edge of their OR starts the set
    assign start_rise = (start_group_a | start_group_b) & ~start_prev_q;

    // Number of samples per conversion, 2 to the power of the active code
    assign target   = `OSA_CNT_W'(1) << ratio_q;
    assign cnt_next = cnt_q + `OSA_CNT_W'(1);

    always_comb begin
        state_d       = state_q;
        busy_d        = busy_q;
        ratio_d       = ratio_q;
        cnt_d         = cnt_q;
        ready_d       = 1'b0;
        result_d      = result_q;
        acc_bus.clear = 1'b0;
        acc_bus.add   = 1'b0;
        sample_strobe = 1'b0;
        case (state_q)
            OSA_IDLE: begin
                // A start during a busy conversion is ignored
                if (start_rise) begin
                    state_d       = OSA_SAMPLE;
                    busy_d        = 1'b1;
                    cnt_d         = '0;
                    acc_bus.clear = 1'b1;
                    sample_strobe = 1'b1;
                end
            end
            OSA_SAMPLE: begin
                if (sample_done) begin
                    acc_bus.add = 1'b1;
                    cnt_d       = cnt_next;
                    if (cnt_next == target) begin
                        state_d = OSA_LOAD;
                    end else begin
                        state_d = OSA_STROBE;
                    end
                end
            end
            OSA_STROBE: begin
                sample_strobe = 1'b1;
                state_d       = OSA_SAMPLE;
            end
            OSA_LOAD: begin
                result_d = avg_w;
                busy_d   = 1'b0;
                ready_d  = 1'b1;
                state_d  = OSA_IDLE;
                // Captured on the same edge busy falls; invalid code falls back to none
                if (ratio_select == `OSA_RATIO_INVALID) begin
                    ratio_d = `OSA_RATIO_NONE;
                end else begin
                    ratio_d = ratio_select;
                end
            end
            default: begin
                state_d = OSA_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q      <= OSA_IDLE;
            busy_q       <= 1'b0;
            ratio_q      <= `OSA_RATIO_RST;
            cnt_q        <= '0;
            ready_q      <= 1'b0;
            result_q     <= '0;
            start_prev_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            busy_q       <= busy_d;
            ratio_q      <= ratio_d;
            cnt_q        <= cnt_d;
            ready_q      <= ready_d;
            result_q     <= result_d;
            start_prev_q <= start_group_a | start_group_b;
        end
    end

    assign acc_bus.shift = ratio_q;

    genvar ch;
    generate
        for (ch = 0; ch < `OSA_CHANNELS; ch++) begin : g_chan
            osa_chan_acc u_acc (
                .clk     (clk),
                .rst_n   (rst_n),
                .ctl     (acc_bus),
                .sample  (sample_data[ch]),
                .average (avg_w[ch])
            );
        end
    endgenerate

    assign busy         = busy_q;
    assign result_ready = ready_q;
    assign result_data  = result_q;

    // Helper: busy cycles so far, only read by the checks below
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_len_q <= '0;
        end else if (busy_q) begin
            busy_len_q <= busy_len_q + `OSA_LEN_W'(1);
        end else begin
            busy_len_q <= '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_start_taken;
        state_q == OSA_IDLE && start_rise;
    endsequence

    sequence s_busy_then_load;
        busy_q [*1] ##0 state_q == OSA_LOAD;
    endsequence

    a_busy_on_start: assert property (s_start_taken |=> busy_q && state_q == OSA_SAMPLE)
        else $error("busy not raised on start");

    a_first_strobe: assert property (s_start_taken |-> sample_strobe)
        else $error("first sample not on start edge");

    a_results_at_fall: assert property (s_busy_then_load |=> !busy_q && result_ready
                                        && result_data == $past(avg_w))
        else $error("results not loaded at busy fall");

    a_ratio_capture: assert property ($fell(busy_q) |-> ratio_q ==
        (($past(ratio_select) == `OSA_RATIO_INVALID) ? `OSA_RATIO_NONE
                                                     : $past(ratio_select)))
        else $error("ratio not captured at busy fall");

    a_ratio_held: assert property (busy_q |=> $stable(ratio_q) || $fell(busy_q))
        else $error("ratio changed during conversion");

    a_sample_count: assert property (state_q == OSA_LOAD |-> cnt_q == target)
        else $error("wrong number of samples averaged");

    a_busy_length: assert property (state_q == OSA_LOAD |->
        busy_len_q >= ({1'b0, target, 1'b0} - 1))
        else $error("busy shorter than ratio requires");

    // A start edge during a conversion must not restart it or clear the sums
    a_no_restart: assert property (state_q != OSA_IDLE |-> !acc_bus.clear)
        else $error("accumulators cleared during conversion");

    a_strobe_source: assert property (sample_strobe |->
        (state_q == OSA_STROBE) || (state_q == OSA_IDLE && start_rise))
        else $error("sample strobe outside a sampling step");

    a_ratio_valid: assert property (ratio_q != `OSA_RATIO_INVALID)
        else $error("invalid ratio code applied");

    a_idle_not_busy: assert property (state_q == OSA_IDLE |-> !busy_q)
        else $error("busy high while idle");

    a_ready_pulse: assert property (result_ready |=> !result_ready)
        else $error("result ready longer than one cycle");

    a_result_hold: assert property (state_q != OSA_LOAD |=> $stable(result_data))
        else $error("results changed outside busy fall");

endmodule : osa_ctrl

// >>> osa_map.svh
// Constants of the oversampling control and averaging filter
`ifndef OSA_MAP_SVH
`define OSA_MAP_SVH

`define OSA_CHANNELS      8
`define OSA_DATA_W        18
`define OSA_ACC_W         24
`define OSA_RATIO_W       3
`define OSA_CNT_W         7
`define OSA_LEN_W         16
`define OSA_RATIO_RST     3'h0
`define OSA_RATIO_INVALID 3'h7
`define OSA_RATIO_NONE    3'h0

`endif

// >>> osa_pkg.sv
// Types of the oversampling control and averaging filter
package osa_pkg;
`include "osa_map.svh"

    typedef logic signed [`OSA_DATA_W-1:0]  osa_sample_t;
    typedef logic signed [`OSA_ACC_W-1:0]   osa_acc_t;
    typedef logic        [`OSA_RATIO_W-1:0] osa_ratio_t;

    typedef enum logic [3:0] {
        OSA_IDLE   = 4'b0001,
        OSA_SAMPLE = 4'b0010,
        OSA_STROBE = 4'b0100,
        OSA_LOAD   = 4'b1000
    } osa_state_t;

endpackage : osa_pkg

// >>> tb_top.sv
// Self-checking bench for the oversampling sequencer and averaging filter
`timescale 1ns/10ps
`include "osa_map.svh"
module tb_top;
    import osa_pkg::*;
    typedef struct { osa_sample_t [`OSA_CHANNELS-1:0] res; int n; } osa_exp_t;
    logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, sample_done;
    logic busy, sample_strobe, result_ready;
    logic [2:0] ratio_select = 3'h0, dly = 3'h2;
    logic [15:0] rnd = 16'h7;
    osa_sample_t [`OSA_CHANNELS-1:0] sample_data = '0, result_data, last_res = '0;
    osa_exp_t expq[$], e, m;
    int sum[`OSA_CHANNELS], cnt, lg, blen, nstb, fail_count, n_compared;
    always #10 clk = ~clk;
    osa_ctrl u_dut (.clk(clk), .rst_n(rst_n), .start_group_a(start), .start_group_b(start),
        .ratio_select(ratio_select), .sample_done(sample_done), .sample_data(sample_data),
        .busy(busy), .sample_strobe(sample_strobe), .result_ready(result_ready),
        .result_data(result_data));
    osa_core_model u_core (.clk(clk), .dly(dly), .sample_strobe(sample_strobe),
        .sample_done(sample_done));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic check(input logic [143:0] seen, input logic [143:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Expected average is built when the N-th sample set is handed over
    always @(posedge clk) begin
        if (sample_done === 1'b1) begin
            for (int c = 0; c < `OSA_CHANNELS; c++) begin
                sum[c] += sample_data[c];
                rnd = lfsr_next(rnd);
                sample_data[c] <= {rnd[1:0], rnd};
            end
            cnt++;
            if (cnt == (1 << lg)) begin
                for (int c = 0; c < `OSA_CHANNELS; c++) begin
                    e.res[c] = osa_sample_t'(sum[c] >>> lg);
                    sum[c] = 0;
                end
                e.n = 1 << lg;
                expq.push_back(e);
                cnt = 0;
            end
        end
    end
    // New results are checked only after busy has fallen, never on the edge itself
    always @(posedge clk) begin
        // Reads while busy is high return the previous conversion's results
        if (busy === 1'b1) begin
            blen++;
            check(result_data, last_res);
        end
        if (sample_strobe === 1'b1) nstb++;
        if (result_ready === 1'b1) begin
            if (expq.size() > 0) begin
                m = expq.pop_front();
                check(result_data, m.res);
                check(144'(nstb), 144'(m.n));
                check(144'(blen >= 2 * m.n + 1), 144'(1));
                last_res = m.res;
            end else check(144'(0), 144'(1));
            blen = 0;
            nstb = 0;
        end
    end
    task automatic conv(input int cur_lg, input logic [2:0] nxt);
        int t;
        lg = cur_lg;
        dly <= 3'h2 + {1'b0, rnd[1:0]};
        start <= 1'b1;
        @(posedge clk);
        ratio_select <= nxt;
        start <= 1'b0;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (busy !== 1'b0 && t < 5000);
        check(144'(busy), 144'(0));
        ratio_select <= rnd[2:0];
        repeat (3) @(posedge clk);
        $display("conversion done, ratio %0d", 1 << cur_lg);
    endtask : conv
    initial begin
        logic [2:0] codes[10] = '{3'h3, 3'h0, 3'h6, 3'h7, 3'h1, 3'h5, 3'h2, 3'h4, 3'h0, 3'h0};
        int prev;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(result_data, '0);
        check(144'(busy), 144'(0));
        prev = 0;
        foreach (codes[k]) begin
            if (k >= 8) codes[k] = 3'(rnd % 7);
            conv(prev, codes[k]);
            prev = (codes[k] == 3'h7) ? 0 : int'(codes[k]);
        end
        conv(prev, 3'h0);
        check(144'(expq.size()), 144'(0));
        end_sim;
    end
    initial begin
        #1_000_000;
        fail_count++;
        end_sim;
    end
endmodule : tb_top
